//--- host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host terminal: sends frames on rxd, captures frames from txd, drives cts.
module host_model (
  input  wire logic core_clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts
);
  int bt = 10; // Cycles per bit.
  initial rxd = 1'b1;
  initial cts = 1'b1;
  // Grants or holds the device's transmitter.
  task automatic hold(input logic v);
    cts <= v;
  endtask
  // Sends nb bits of f first bit first from a rising edge; the closing stop bit leaves the line high.
  task automatic send(input logic [11:0] f, input int nb);
    @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge core_clk);
    end
  endtask
  // Samples nb bits at bit centres after a falling edge.
  task automatic recv(output logic [11:0] f, input int nb);
    f = 12'h000;
    for (int n = 0; n < 4000 && txd; n++) @(negedge core_clk);
    repeat (bt / 2) @(negedge core_clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      repeat (bt) @(negedge core_clk);
    end
  endtask
endmodule // host_model
`default_nettype wire

//--- serial_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the keypad menu and the serial output.
module serial_port_asserts (
  // Clock, reset and line
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       txd,
  // Keypad
  input wire logic       program_mode,
  input wire logic       serial_setup_function,
  input wire logic       key_plus,
  input wire logic       key_enter,
  input wire logic       key_set,
  input wire logic [5:0] menu_field,
  input wire logic [2:0] menu_value,
  input wire logic       menu_blink
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // The shortest bit at the bench's clock setting lasts 5 cycles.
  field_onehot_a: assert property ($onehot(menu_field))
    else $error("menu position not one-hot");
  setup_open_a: assert property (menu_field == 6'h01 && program_mode && serial_setup_function |=> menu_field == 6'h02)
    else $error("setup did not open");
  setup_abort_a: assert property (!program_mode |=> menu_field == 6'h01)
    else $error("setup kept outside program mode");
  idle_hold_a: assert property (menu_field == 6'h01 && !(program_mode && serial_setup_function) |=> menu_field == 6'h01)
    else $error("menu left idle");
  set_step_a: assert property (program_mode && key_set && menu_field != 6'h01 |=>
    menu_field == ($past(menu_field) == 6'h20 ? 6'h01 : $past(menu_field) << 1))
    else $error("set did not advance");
  enter_commit_a: assert property (program_mode && key_enter && menu_field != 6'h01 |=> !menu_blink)
    else $error("candidate still blinking");
  plus_step_a: assert property (program_mode && key_plus && menu_field == 6'h04 && menu_value == 3'h0 |=>
    menu_value == 3'h1 && menu_blink == !$past(menu_blink))
    else $error("plus did not step");
  low_bit_a: assert property ($fell(txd) |-> !txd [*5])
    else $error("low bit too short");
  high_bit_a: assert property ($rose(txd) |-> txd [*5])
    else $error("high bit too short");
endmodule // serial_port_asserts
bind serial_port_flow_control serial_port_asserts serial_port_asserts_i (.core_clk(core_clk), .arst_n(arst_n),
  .txd(txd), .program_mode(program_mode), .serial_setup_function(serial_setup_function), .key_plus(key_plus),
  .key_enter(key_enter), .key_set(key_set), .menu_field(menu_field), .menu_value(menu_value), .menu_blink(menu_blink));
`default_nettype wire

//--- serial_port_flow_control.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_params.svh"

// Synchronous FIFO with valid and ready on both sides.
module sp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two of at least four.
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sp_fifo: DEPTH must be a power of two, at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Full and empty come from the pointer difference.
  assign level     = wr_ptr_q - rd_ptr_q;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr_q[AW-1:0]];

  // Storage array.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, push};
      rd_ptr_q <= rd_ptr_q + {{AW{1'b0}}, pop};
    end
  end
endmodule // sp_fifo

// Serial port with keypad setup and receive flow control.
module serial_port_flow_control #(
  parameter int CLK_HZ   = `SP_CLK_HZ,
  parameter int GRACE_MS = `SP_GRACE_MS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Serial link
  output logic             txd,
  input  wire logic        rxd,
  output logic             rts,
  input  wire logic        cts,
  // Keypad setup
  input  wire logic        program_mode,
  input  wire logic        serial_setup_function,
  input  wire logic        key_plus,
  input  wire logic        key_minus,
  input  wire logic        key_enter,
  input  wire logic        key_set,
  output logic [5:0]       menu_field,
  output logic [2:0]       menu_value,
  output logic             menu_blink
);
  localparam int CW        = 24;
  localparam int GRACE_CYC = (CLK_HZ / 1000) * GRACE_MS;

  // Counters must hold the slowest bit time and the grace interval.
  if (CLK_HZ / `SP_BAUD_4 >= (1 << CW) || GRACE_CYC >= (1 << CW) || CLK_HZ / `SP_BAUD_0 < 4) begin : g_bad_timing
    $error("serial_port_flow_control: CLK_HZ or GRACE_MS out of range");
  end

  // Bit time in clock cycles for a baud index.
  function automatic logic [CW-1:0] bit_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    bit_cycles = CW'(CLK_HZ / `SP_BAUD_0);
      3'h1:    bit_cycles = CW'(CLK_HZ / `SP_BAUD_1);
      3'h2:    bit_cycles = CW'(CLK_HZ / `SP_BAUD_2);
      3'h3:    bit_cycles = CW'(CLK_HZ / `SP_BAUD_3);
      default: bit_cycles = CW'(CLK_HZ / `SP_BAUD_4);
    endcase
  endfunction

  // Parity bit for a character under the given settings.
  function automatic logic par_bit(input logic [7:0] d, input serial_port_pkg::port_cfg_s c);
    logic ones;
    ones    = ^(c.data8 ? d : {1'b0, d[6:0]});
    par_bit = (c.parity == serial_port_pkg::PAR_ODD) ? ~ones : ones;
  endfunction

  serial_port_pkg::port_cfg_s cfg_q, stage_q;
  serial_port_pkg::menu_e     menu_q, menu_d;
  logic [2:0]                 cand_q, cand_d;
  logic [2:0]                 field_val, field_max, next_val;
  logic                       apply_cfg, blink_d, blink_q;

  // Committed value and range of the field under edit.
  assign field_val = (menu_q == serial_port_pkg::MENU_BAUD)   ? stage_q.baud_sel :
                     (menu_q == serial_port_pkg::MENU_DBITS)  ? {2'h0, stage_q.data8} :
                     (menu_q == serial_port_pkg::MENU_SBITS)  ? {2'h0, stage_q.stop2} :
                     (menu_q == serial_port_pkg::MENU_PARITY) ? {1'b0, stage_q.parity} :
                                                                {2'h0, stage_q.sw_proto};
  assign field_max = (menu_q == serial_port_pkg::MENU_BAUD)   ? `SP_BAUD_MAX_SEL :
                     (menu_q == serial_port_pkg::MENU_PARITY) ? 3'h2 : 3'h1;
  assign apply_cfg = (menu_q == serial_port_pkg::MENU_PROTO) & key_set & program_mode;
  assign blink_d   = (menu_d == menu_q) & (menu_q != serial_port_pkg::MENU_IDLE) & ~key_enter & (cand_d != field_val);

  // Field sequence; set moves on, leaving program mode aborts.
  always_comb begin
    menu_d = menu_q;
    if (!program_mode) begin
      menu_d = serial_port_pkg::MENU_IDLE;
    end else if (key_set) begin
      case (menu_q)
        serial_port_pkg::MENU_BAUD:   menu_d = serial_port_pkg::MENU_DBITS;
        serial_port_pkg::MENU_DBITS:  menu_d = serial_port_pkg::MENU_SBITS;
        serial_port_pkg::MENU_SBITS:  menu_d = serial_port_pkg::MENU_PARITY;
        serial_port_pkg::MENU_PARITY: menu_d = serial_port_pkg::MENU_PROTO;
        serial_port_pkg::MENU_PROTO:  menu_d = serial_port_pkg::MENU_IDLE;
        default:                      menu_d = serial_port_pkg::MENU_IDLE;
      endcase
    end else if (menu_q == serial_port_pkg::MENU_IDLE && serial_setup_function) begin
      menu_d = serial_port_pkg::MENU_BAUD;
    end
  end

  // Candidate stepping with wrap at both ends of the field range.
  assign next_val = key_plus  ? ((cand_q >= field_max) ? 3'h0 : cand_q + 3'h1) :
                    key_minus ? ((cand_q == 3'h0) ? field_max : cand_q - 3'h1) : cand_q;
  always_comb begin
    cand_d = next_val;
    if (menu_d != menu_q) begin
      case (menu_d)
        serial_port_pkg::MENU_BAUD:   cand_d = cfg_q.baud_sel;
        serial_port_pkg::MENU_DBITS:  cand_d = {2'h0, stage_q.data8};
        serial_port_pkg::MENU_SBITS:  cand_d = {2'h0, stage_q.stop2};
        serial_port_pkg::MENU_PARITY: cand_d = {1'b0, stage_q.parity};
        serial_port_pkg::MENU_PROTO:  cand_d = {2'h0, stage_q.sw_proto};
        default:                      cand_d = 3'h0;
      endcase
    end
  end

  // Menu state, staged settings and active settings.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      menu_q  <= serial_port_pkg::MENU_IDLE;
      cand_q  <= 3'h0;
      blink_q <= 1'b0;
      cfg_q   <= '{`SP_RST_BAUD_SEL, `SP_RST_DATA8, `SP_RST_STOP2, serial_port_pkg::PAR_ODD, `SP_RST_SW_PROTO};
      stage_q <= '{`SP_RST_BAUD_SEL, `SP_RST_DATA8, `SP_RST_STOP2, serial_port_pkg::PAR_ODD, `SP_RST_SW_PROTO};
    end else begin
      menu_q <= menu_d;
      cand_q <= cand_d;
      blink_q <= blink_d;
      if (menu_q == serial_port_pkg::MENU_IDLE && menu_d == serial_port_pkg::MENU_BAUD) begin
        stage_q <= cfg_q;
      end else if (key_enter && program_mode) begin
        case (menu_q)
          serial_port_pkg::MENU_BAUD:   stage_q.baud_sel <= cand_q;
          serial_port_pkg::MENU_DBITS:  stage_q.data8    <= cand_q[0];
          serial_port_pkg::MENU_SBITS:  stage_q.stop2    <= cand_q[0];
          serial_port_pkg::MENU_PARITY: stage_q.parity   <= serial_port_pkg::parity_e'(cand_q[1:0]);
          serial_port_pkg::MENU_PROTO:  stage_q.sw_proto <= cand_q[0];
          default:                      stage_q          <= stage_q;
        endcase
      end
      if (apply_cfg) begin
        cfg_q <= stage_q;
      end
    end
  end

  logic [CW-1:0] bit_len;
  logic [3:0]    n_data;
  assign bit_len = bit_cycles(cfg_q.baud_sel);
  assign n_data  = cfg_q.data8 ? 4'h8 : 4'h7;

  serial_port_pkg::frame_e rx_st_q;
  logic [CW-1:0] rx_cnt_q;
  logic [3:0]    rx_bit_q;
  logic [7:0]    rx_sh_q;
  logic          rx_perr_q;
  logic          rx_ferr_q;
  logic          rx_done;
  logic          rx_tick;
  assign rx_tick = (rx_st_q == serial_port_pkg::FR_START) ? (rx_cnt_q == {1'b0, bit_len[CW-1:1]}) :
                                                            (rx_cnt_q == bit_len - CW'(1));
  assign rx_done = rx_tick & (rx_st_q == serial_port_pkg::FR_STOP) & (rx_bit_q == {3'h0, cfg_q.stop2});

  // Start bit check at mid bit, then one sample per bit time.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q   <= serial_port_pkg::FR_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_cnt_q <= (rx_tick || rx_st_q == serial_port_pkg::FR_IDLE) ? '0 : rx_cnt_q + CW'(1);
      case (rx_st_q)
        serial_port_pkg::FR_IDLE: begin
          if (!rxd) begin
            rx_st_q   <= serial_port_pkg::FR_START;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
          end
        end
        serial_port_pkg::FR_START: begin
          if (rx_tick) begin
            rx_st_q  <= rxd ? serial_port_pkg::FR_IDLE : serial_port_pkg::FR_DATA;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 8'h00;
          end
        end
        serial_port_pkg::FR_DATA: begin
          if (rx_tick) begin
            rx_sh_q[rx_bit_q[2:0]] <= rxd;
            rx_bit_q               <= rx_bit_q + 4'h1;
            if (rx_bit_q == n_data - 4'h1) begin
              rx_bit_q <= 4'h0;
              rx_st_q  <= (cfg_q.parity == serial_port_pkg::PAR_NONE) ? serial_port_pkg::FR_STOP :
                                                                       serial_port_pkg::FR_PAR;
            end
          end
        end
        serial_port_pkg::FR_PAR: begin
          if (rx_tick) begin
            rx_perr_q <= (rxd != par_bit(rx_sh_q, cfg_q));
            rx_st_q   <= serial_port_pkg::FR_STOP;
          end
        end
        serial_port_pkg::FR_STOP: begin
          if (rx_tick) begin
            rx_ferr_q <= rx_ferr_q | ~rxd;
            rx_bit_q  <= rx_bit_q + 4'h1;
            if (rx_done) begin
              rx_st_q <= serial_port_pkg::FR_IDLE;
            end
          end
        end
        default: rx_st_q <= serial_port_pkg::FR_IDLE;
      endcase
    end
  end

  logic          hold_q;
  logic [CW-1:0] grace_q;
  logic [1:0]    late_q;
  logic          peer_xoff_q;
  logic          is_flow_char;
  logic          accept;
  logic          push;
  logic          fifo_ready;
  logic [3:0]    fifo_level;
  logic          fifo_valid;
  logic [7:0]    fifo_data;
  logic          pop;
  logic [7:0]    rx_char;
  logic          rx_frame_err;

  assign rx_char      = rx_sh_q;
  assign rx_frame_err = rx_ferr_q | ~rxd;
  assign is_flow_char = cfg_q.sw_proto & ((rx_char == `SP_CHAR_XON) | (rx_char == `SP_CHAR_XOFF));
  // Late characters count only inside the grace window and up to the limit.
  assign accept = ~hold_q | ((grace_q != '0) & (late_q != 2'(`SP_GRACE_CHARS)));
  assign push   = rx_done & ~is_flow_char & accept;

  sp_fifo #(
    .WIDTH (8),
    .DEPTH (`SP_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (rx_char),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // Hold the partner when two slots remain, release at the resume level.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q      <= 1'b0;
      grace_q     <= '0;
      late_q      <= 2'h0;
      peer_xoff_q <= 1'b0;
    end else begin
      if (!hold_q && fifo_level >= 4'(`SP_FIFO_DEPTH - `SP_GRACE_CHARS)) begin
        hold_q  <= 1'b1;
        grace_q <= CW'(GRACE_CYC);
        late_q  <= 2'h0;
      end else if (hold_q && fifo_level <= 4'(`SP_RESUME_LEVEL)) begin
        hold_q <= 1'b0;
      end else if (grace_q != '0) begin
        grace_q <= grace_q - CW'(1);
      end
      if (hold_q && push) begin
        late_q <= late_q + 2'h1;
      end
      if (rx_done && is_flow_char) begin
        peer_xoff_q <= (rx_char == `SP_CHAR_XOFF);
      end else if (!cfg_q.sw_proto) begin
        peer_xoff_q <= 1'b0;
      end
    end
  end

  serial_port_pkg::frame_e tx_st_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0]    tx_bit_q;
  logic [7:0]    tx_sh_q;
  logic          tx_par_q;
  logic [7:0]    tx_hold_q;
  logic          tx_full_q;
  logic          fc_pend_q;
  logic          fc_sent_q;
  logic          tx_end;
  logic          tx_go_fc;
  logic          tx_go_data;
  logic          tx_ok;
  logic          txd_q;
  logic          wr_data;

  assign tx_end     = (tx_cnt_q == bit_len - CW'(1));
  assign tx_ok      = cfg_q.sw_proto ? ~peer_xoff_q : cts;
  assign tx_go_fc   = (tx_st_q == serial_port_pkg::FR_IDLE) & fc_pend_q;
  assign tx_go_data = (tx_st_q == serial_port_pkg::FR_IDLE) & ~fc_pend_q & tx_full_q & tx_ok;
  assign wr_data    = reg_wr & (reg_addr == `SP_OFF_DATA);

  // Holding register and flow character request; a new request beats a take.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      fc_pend_q <= 1'b0;
      fc_sent_q <= 1'b0;
    end else begin
      if (wr_data && !tx_full_q) begin
        tx_hold_q <= reg_wdata;
        tx_full_q <= 1'b1;
      end else if (tx_go_data) begin
        tx_full_q <= 1'b0;
      end
      if (cfg_q.sw_proto && hold_q != fc_sent_q) begin
        fc_pend_q <= 1'b1;
        fc_sent_q <= hold_q;
      end else if (tx_go_fc) begin
        fc_pend_q <= 1'b0;
      end
    end
  end

  // Start, data LSB first, optional parity, stop bits.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q  <= serial_port_pkg::FR_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 8'h00;
      tx_par_q <= 1'b0;
      txd_q    <= 1'b1;
    end else begin
      tx_cnt_q <= (tx_end || tx_st_q == serial_port_pkg::FR_IDLE) ? '0 : tx_cnt_q + CW'(1);
      case (tx_st_q)
        serial_port_pkg::FR_IDLE: begin
          txd_q <= 1'b1;
          if (tx_go_fc || tx_go_data) begin
            tx_sh_q  <= tx_go_fc ? (fc_sent_q ? `SP_CHAR_XOFF : `SP_CHAR_XON) : tx_hold_q;
            tx_par_q <= par_bit(tx_go_fc ? (fc_sent_q ? `SP_CHAR_XOFF : `SP_CHAR_XON) : tx_hold_q, cfg_q);
            tx_st_q  <= serial_port_pkg::FR_START;
            txd_q    <= 1'b0;
          end
        end
        serial_port_pkg::FR_START: begin
          if (tx_end) begin
            tx_st_q  <= serial_port_pkg::FR_DATA;
            tx_bit_q <= 4'h1;
            txd_q    <= tx_sh_q[0];
          end
        end
        serial_port_pkg::FR_DATA: begin
          if (tx_end) begin
            tx_bit_q <= tx_bit_q + 4'h1;
            txd_q    <= tx_sh_q[tx_bit_q[2:0]];
            if (tx_bit_q == n_data) begin
              tx_bit_q <= 4'h0;
              tx_st_q  <= (cfg_q.parity == serial_port_pkg::PAR_NONE) ? serial_port_pkg::FR_STOP :
                                                                       serial_port_pkg::FR_PAR;
              txd_q    <= (cfg_q.parity == serial_port_pkg::PAR_NONE) ? 1'b1 : tx_par_q;
            end
          end
        end
        serial_port_pkg::FR_PAR: begin
          if (tx_end) begin
            tx_st_q <= serial_port_pkg::FR_STOP;
            txd_q   <= 1'b1;
          end
        end
        serial_port_pkg::FR_STOP: begin
          txd_q <= 1'b1;
          if (tx_end) begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == {3'h0, cfg_q.stop2}) begin
              tx_st_q <= serial_port_pkg::FR_IDLE;
            end
          end
        end
        default: tx_st_q <= serial_port_pkg::FR_IDLE;
      endcase
    end
  end

  logic       perr_q;
  logic       ferr_q;
  logic       ovr_q;
  logic       rd_status;
  logic       drop;
  logic [7:0] status_w;
  logic [7:0] cfg_w;
  logic [7:0] rdata_q;
  logic       rts_q;

  assign pop       = reg_rd & (reg_addr == `SP_OFF_DATA) & fifo_valid;
  assign rd_status = reg_rd & (reg_addr == `SP_OFF_STATUS);
  assign drop      = rx_done & ~is_flow_char & (~accept | ~fifo_ready);
  assign status_w  = {1'b0, ~tx_ok, hold_q, ovr_q, ferr_q, perr_q, tx_full_q, fifo_valid};
  assign cfg_w     = {cfg_q.sw_proto, cfg_q.parity, cfg_q.stop2, cfg_q.data8, cfg_q.baud_sel};

  // Sticky errors clear on a status read; a new error in that cycle wins.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      perr_q  <= 1'b0;
      ferr_q  <= 1'b0;
      ovr_q   <= 1'b0;
      rdata_q <= 8'h00;
      rts_q   <= 1'b0;
    end else begin
      perr_q  <= (rx_done & rx_perr_q) | (perr_q & ~rd_status);
      ferr_q  <= (rx_done & rx_frame_err) | (ferr_q & ~rd_status);
      ovr_q   <= drop | (ovr_q & ~rd_status);
      rts_q   <= cfg_q.sw_proto | ~hold_q;
      rdata_q <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `SP_OFF_DATA:   rdata_q <= fifo_valid ? fifo_data : 8'h00;
          `SP_OFF_STATUS: rdata_q <= status_w;
          `SP_OFF_CONFIG: rdata_q <= cfg_w;
          default:        rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata  = rdata_q;
  assign txd        = txd_q;
  assign rts        = rts_q;
  assign menu_field = menu_q;
  assign menu_value = cand_q;
  assign menu_blink = blink_q;
endmodule // serial_port_flow_control

`default_nettype wire

//--- serial_port_flow_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the serial port.
module serial_port_flow_control_bench;
  logic        core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, program_mode = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [4:0]  kv = 5'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [5:0]  menu_field;
  logic [2:0]  menu_value;
  logic        txd, rxd, rts, cts, menu_blink;
  logic [11:0] f;
  int          fail_count = 0, comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  serial_port_flow_control #(.CLK_HZ(96000), .GRACE_MS(2)) serial_port_flow_control_i (.core_clk(core_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .rts(rts), .cts(cts), .program_mode(program_mode),
    .serial_setup_function(kv[0]), .key_plus(kv[1]), .key_minus(kv[2]), .key_enter(kv[3]), .key_set(kv[4]),
    .menu_field(menu_field), .menu_value(menu_value), .menu_blink(menu_blink));
  host_model host_model_i (.core_clk(core_clk), .txd(txd), .rxd(rxd), .cts(cts));
  // Frame bits, first on the line at bit 0.
  function automatic logic [11:0] fr(input logic [7:0] d, input logic d8, input logic odd);
    logic p;
    p = ^(d8 ? d : {1'b0, d[6:0]}) ^ odd;
    fr = d8 ? {2'b11, p, d, 1'b0} : {3'b111, p, d[6:0], 1'b0};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic key(input int w);
    @(posedge core_clk);
    kv <= 5'h01 << w;
    @(posedge core_clk);
    kv <= 5'h00;
    #1;
  endtask
  task automatic s_reset;
    rdc(4'h8, 8'h21);
    wr(4'h8, 8'hFF);
    rdc(4'h8, 8'h21);
    rdc(4'hC, 8'h00);
  endtask
  task automatic s_tx(input logic [7:0] d, input logic d8, input logic odd, input int nb);
    wr(4'h0, d);
    host_model_i.recv(f, nb);
    chk(f, fr(d, d8, odd) & ~(12'hFFF << nb));
  endtask
  task automatic s_keys;
    int ks[12] = '{0, 2, 3, 4, 1, 3, 4, 4, 1, 3, 4, 4};
    @(posedge core_clk) program_mode <= 1'b1;
    foreach (ks[i]) begin
      key(ks[i]);
      if (i == 4) chk(menu_blink, 1'b1);
    end
    chk(menu_field, 6'h01);
    rdc(4'h8, 8'h48);
    host_model_i.bt = 5;
  endtask
  task automatic s_flow;
    for (int i = 0; i < 9; i++) begin
      host_model_i.send(fr(8'h30 + i, 1'b1, 1'b0), 11);
      if (i == 6) chk(rts, 1'b0);
    end
    rdc(4'h4, 8'h31);
    for (int i = 0; i < 8; i++) rdc(4'h0, 8'h30 + i);
    rdc(4'h0, 8'h00);
    chk(rts, 1'b1);
  endtask
  task automatic s_cts;
    int ks[8] = '{0, 4, 4, 4, 4, 1, 3, 4};
    host_model_i.hold(1'b0);
    wr(4'h0, 8'h5A);
    repeat (40) @(posedge core_clk);
    chk(txd, 1'b1);
    rdc(4'h4, 8'h42);
    host_model_i.hold(1'b1);
    host_model_i.recv(f, 11);
    chk(f, fr(8'h5A, 1'b1, 1'b0) & 12'h7FF);
    foreach (ks[i]) key(ks[i]);
    host_model_i.send(fr(8'h13, 1'b1, 1'b0), 11);
    wr(4'h0, 8'h66);
    repeat (20) @(posedge core_clk);
    rdc(4'h4, 8'h42);
    host_model_i.send(fr(8'h11, 1'b1, 1'b0), 11);
    host_model_i.recv(f, 11);
    chk(f, fr(8'h66, 1'b1, 1'b0) & 12'h7FF);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    s_reset;
    s_tx(8'h41, 1'b0, 1'b1, 10);
    host_model_i.send(fr(8'h35, 1'b0, 1'b1), 10);
    rdc(4'h0, 8'h35);
    s_keys;
    s_tx(8'hC3, 1'b1, 1'b0, 11);
    s_flow;
    s_cts;
    tally_and_finish;
  end
  // Watchdog against a hang.
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
endmodule // serial_port_flow_control_bench
`default_nettype wire

//--- serial_port_params.svh
// Functional notes
// - Baud rate selectable 19200, 9600, 4800, 2400, 1200; bit timing follows it.
// - Seven or eight data bits per character, for transmit and receive.
// - One or two stop bits sent and expected.
// - Parity odd, even or none; generated on transmit, checked on receive.
// - Flow control selectable: hardware RTS/CTS or software XON/XOFF.
// - Reset settings: 9600 baud, 7 data bits, 1 stop, odd parity, RTS/CTS.
// - Hardware mode: RTS shows readiness to receive, CTS gates transmission.
// - After a stop request, keep accepting up to 2 characters for 30 ms.
// - Characters beyond those two or after 30 ms are discarded.
// - Software mode uses code 17 to resume and code 19 to stop.
// - Data terminal end with only data and RTS/CTS lines, no DTR/DSR.
// - Port settings change only from the keypad, never over the link.
// - Port setup is reachable only in program mode.
// - Plus/minus step candidate, enter commits, set advances through five fields.
// - Set after protocol field ends setup and applies committed settings.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Register offsets on the software port.
`define SP_OFF_DATA      4'h0
`define SP_OFF_STATUS    4'h4
`define SP_OFF_CONFIG    4'h8

// Status register bit positions.
`define SP_ST_RX_AVAIL   0
`define SP_ST_TX_BUSY    1
`define SP_ST_PAR_ERR    2
`define SP_ST_FRM_ERR    3
`define SP_ST_OVERRUN    4
`define SP_ST_RX_HOLD    5
`define SP_ST_TX_HOLD    6

// Flow control characters.
`define SP_CHAR_XON      8'h11
`define SP_CHAR_XOFF     8'h13

// Baud rate table, selected by index 0 to 4.
`define SP_BAUD_0        19200
`define SP_BAUD_1        9600
`define SP_BAUD_2        4800
`define SP_BAUD_3        2400
`define SP_BAUD_4        1200
`define SP_BAUD_MAX_SEL  3'h4

// Reset settings of the port.
`define SP_RST_BAUD_SEL  3'h1
`define SP_RST_DATA8     1'b0
`define SP_RST_STOP2     1'b0
`define SP_RST_SW_PROTO  1'b0

// Timing.
`define SP_CLK_HZ        200000000
`define SP_GRACE_MS      30
`define SP_GRACE_CHARS   2

// Receive buffer levels that stop and resume the partner.
`define SP_FIFO_DEPTH    8
`define SP_RESUME_LEVEL  2

`endif

//--- serial_port_pkg.sv
package serial_port_pkg;

  // Parity selection.
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ODD  = 2'h1,
    PAR_EVEN = 2'h2
  } parity_e;

  // Active or staged port settings.
  typedef struct packed {
    logic [2:0] baud_sel;
    logic       data8;
    logic       stop2;
    parity_e    parity;
    logic       sw_proto;
  } port_cfg_s;

  // Setup menu position.
  typedef enum logic [5:0] {
    MENU_IDLE   = 6'h01,
    MENU_BAUD   = 6'h02,
    MENU_DBITS  = 6'h04,
    MENU_SBITS  = 6'h08,
    MENU_PARITY = 6'h10,
    MENU_PROTO  = 6'h20
  } menu_e;

  // Serial frame position, shared by transmitter and receiver.
  typedef enum logic [4:0] {
    FR_IDLE  = 5'h01,
    FR_START = 5'h02,
    FR_DATA  = 5'h04,
    FR_PAR   = 5'h08,
    FR_STOP  = 5'h10
  } frame_e;

endpackage
